// ==== shared/ipsl_pkg.sv ====
// Constants, register map and carrier types of the interrupt priority and state block
package ipsl_pkg;

  // Implementation size: interrupt count and index width
  localparam int NUM_IRQ = 32;
  localparam int IRQ_W = 5;

  // Priority fields: 8 bits each, four to a word, upper bits implemented
  localparam int PRIO_W = 8;
  localparam int LANES = 4;
  localparam int LANE_W = 2;
  localparam int PRIO_REG_W = 3;
  localparam logic [7:0] PRIO_MASK = 8'hF0;

  // Register bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [11:0] OFS_ENA_SET = 12'h100;
  localparam logic [11:0] OFS_ENA_CLR = 12'h180;
  localparam logic [11:0] OFS_PEND_SET = 12'h200;
  localparam logic [11:0] OFS_PEND_CLR = 12'h280;
  localparam logic [11:0] OFS_ACTIVE = 12'h300;
  localparam logic [11:0] OFS_PRIO_BASE = 12'h400;
  localparam logic [11:0] OFS_PRIO_LAST = 12'h41C;
  localparam logic [11:0] OFS_CTRL = 12'hD10;
  localparam logic [11:0] OFS_TRIGGER = 12'hF00;

  // Field positions
  localparam int CTRL_PERMIT_BIT = 1;
  localparam int TRIG_NUM_HI = 8;
  localparam int TRIG_NUM_W = 9;

  // Reset values
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [7:0] RESET_PRIO = 8'h00;
  localparam logic [31:0] PULSE_LINES_DEFAULT = 32'h0000_0000;

  // Processor handler entry and return, one pulse each
  typedef struct packed {
    logic enter;
    logic ret;
    logic [IRQ_W-1:0] num;
  } ipsl_cpu_req_t;

  // Interrupt offered to the processor
  typedef struct packed {
    logic valid;
    logic [IRQ_W-1:0] num;
    logic [PRIO_W-1:0] prio;
  } ipsl_take_t;

endpackage

// ==== rtl/ipsl_core.sv ====
// Interrupt priority array, software trigger and per-interrupt state tracking
`timescale 1ns/1ps
`default_nettype none

module ipsl_core #(
  parameter logic [31:0] LINE_IS_PULSE = ipsl_pkg::PULSE_LINES_DEFAULT
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [ipsl_pkg::ADDR_W-1:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [ipsl_pkg::DATA_W-1:0] wb_dat_i,
  output logic [ipsl_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack,
  output logic wb_err,
  input wire logic bus_priv,
  input wire logic [ipsl_pkg::NUM_IRQ-1:0] irq_lines,
  input wire ipsl_pkg::ipsl_cpu_req_t cpu_req,
  output ipsl_pkg::ipsl_take_t take
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte selects widened to a bit mask
  function automatic logic [31:0] byte_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int l = 0; l < ipsl_pkg::LANES; l++) begin
      m[l*ipsl_pkg::PRIO_W +: ipsl_pkg::PRIO_W] = {ipsl_pkg::PRIO_W{sel[l]}};
    end
    return m;
  endfunction

  // One-hot vector for an interrupt number, zero when enabled low
  function automatic logic [ipsl_pkg::NUM_IRQ-1:0] one_hot(
    input logic en,
    input logic [ipsl_pkg::IRQ_W-1:0] num
  );
    logic [ipsl_pkg::NUM_IRQ-1:0] v;
    v = '0;
    if (en) begin
      v[num] = 1'b1;
    end
    return v;
  endfunction

  // Register match against one offset, shared by every decoded register except the priority range
  function automatic logic hit(
    input logic [ipsl_pkg::ADDR_W-1:0] adr,
    input logic [ipsl_pkg::ADDR_W-1:0] ofs
  );
    return adr == ofs;
  endfunction

  // Array index of lane l in priority word r, interrupt 4r+l
  function automatic logic [ipsl_pkg::IRQ_W-1:0] prio_slot(
    input logic [ipsl_pkg::PRIO_REG_W-1:0] r,
    input int l
  );
    return {r, ipsl_pkg::LANE_W'(l)};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [ipsl_pkg::NUM_IRQ-1:0] enabled;
  logic [ipsl_pkg::NUM_IRQ-1:0] pending;
  logic [ipsl_pkg::NUM_IRQ-1:0] active;
  logic [ipsl_pkg::NUM_IRQ-1:0] prev_lines;
  logic [ipsl_pkg::PRIO_W-1:0] prio [ipsl_pkg::NUM_IRQ];
  logic user_trigger_permit;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic req;
  logic first;
  logic commit;
  logic aligned;
  logic is_ena_set;
  logic is_ena_clr;
  logic is_pend_set;
  logic is_pend_clr;
  logic is_active;
  logic is_prio;
  logic is_ctrl;
  logic is_trig;
  logic mapped;
  logic allowed;
  logic [ipsl_pkg::PRIO_REG_W-1:0] prio_reg;
  logic [31:0] wmask;
  logic [31:0] wval;

  // Request sampled once; the write lands on the edge where ack is seen
  // first is low while an answer stands, so each request is taken once
  assign req = wb_cyc & wb_stb;
  assign first = req & ~wb_ack & ~wb_err;
  assign commit = req & wb_we & wb_ack;
  assign wmask = byte_mask(wb_sel);
  assign wval = wb_dat_i & wmask;

  // Misaligned addresses decode as unmapped and get an error
  assign aligned = (wb_adr[1:0] == 2'h0);
  assign is_ena_set = aligned & hit(wb_adr, ipsl_pkg::OFS_ENA_SET);
  assign is_ena_clr = aligned & hit(wb_adr, ipsl_pkg::OFS_ENA_CLR);
  assign is_pend_set = aligned & hit(wb_adr, ipsl_pkg::OFS_PEND_SET);
  assign is_pend_clr = aligned & hit(wb_adr, ipsl_pkg::OFS_PEND_CLR);
  assign is_active = aligned & hit(wb_adr, ipsl_pkg::OFS_ACTIVE);
  assign is_ctrl = aligned & hit(wb_adr, ipsl_pkg::OFS_CTRL);
  assign is_trig = aligned & hit(wb_adr, ipsl_pkg::OFS_TRIGGER);
  assign is_prio = aligned & (wb_adr >= ipsl_pkg::OFS_PRIO_BASE)
                 & (wb_adr <= ipsl_pkg::OFS_PRIO_LAST);
  // Word number within the priority array, interrupt m in word m/4
  assign prio_reg = wb_adr[ipsl_pkg::PRIO_REG_W+1:2];
  assign mapped = is_ena_set | is_ena_clr | is_pend_set | is_pend_clr | is_active
                | is_prio | is_ctrl | is_trig;

  // Everything is privileged except the trigger while permitted
  assign allowed = mapped & (bus_priv | (is_trig & user_trigger_permit));

  // Single-cycle answer: ack one cycle after an allowed request is seen
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack <= 1'b0;
    end else begin
      wb_ack <= first & allowed;
    end
  end

  // Err one cycle after a refused or unmapped request is seen
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_err <= 1'b0;
    end else begin
      wb_err <= first & ~allowed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  logic [31:0] rd_word;
  logic [31:0] prio_word;

  // The four lanes of the addressed priority word, low bits forced to zero
  always_comb begin
    prio_word = 32'h0000_0000;
    for (int l = 0; l < ipsl_pkg::LANES; l++) begin
      prio_word[l*ipsl_pkg::PRIO_W +: ipsl_pkg::PRIO_W] =
        prio[prio_slot(prio_reg, l)] & ipsl_pkg::PRIO_MASK;
    end
  end

  // Read mux; trigger is write-only and reads zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (is_ena_set | is_ena_clr) begin
      rd_word = enabled;
    end else if (is_pend_set | is_pend_clr) begin
      rd_word = pending;
    end else if (is_active) begin
      rd_word = active;
    end else if (is_ctrl) begin
      rd_word[ipsl_pkg::CTRL_PERMIT_BIT] = user_trigger_permit;
    end else if (is_prio) begin
      rd_word = prio_word;
    end
  end

  // Read data captured with the answer; unselected lanes read zero
  // Writes and refused accesses return zero, so no stale word leaks out
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_dat_o <= ipsl_pkg::RESET_WORD;
    end else if (first) begin
      wb_dat_o <= (allowed & ~wb_we) ? (rd_word & wmask) : ipsl_pkg::RESET_WORD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software writes

  logic [ipsl_pkg::NUM_IRQ-1:0] sw_set;
  logic [ipsl_pkg::NUM_IRQ-1:0] sw_clr;
  logic [ipsl_pkg::NUM_IRQ-1:0] trig_vec;
  logic [ipsl_pkg::TRIG_NUM_W-1:0] trigger_irq_number;
  logic trig_ok;

  // Set and clear pending words, cut to the selected byte lanes
  assign sw_set = (commit & is_pend_set) ? wval : '0;
  assign sw_clr = (commit & is_pend_clr) ? wval : '0;

  // Trigger number in bits 8..0; out-of-range numbers fall out here
  // Bits 31..9 are reserved and never looked at
  assign trigger_irq_number = wval[ipsl_pkg::TRIG_NUM_HI:0];
  assign trig_ok = commit & is_trig
                 & (trigger_irq_number < ipsl_pkg::TRIG_NUM_W'(ipsl_pkg::NUM_IRQ));
  assign trig_vec = one_hot(trig_ok, trigger_irq_number[ipsl_pkg::IRQ_W-1:0]);

  // Enable set and clear; set wins if both land together
  // They sit at separate offsets, so one write never carries both
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      enabled <= '0;
    end else if (commit & is_ena_set) begin
      enabled <= enabled | wval;
    end else if (commit & is_ena_clr) begin
      enabled <= enabled & ~wval;
    end
  end

  // Permit bit; allowed already demands privilege for this offset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      user_trigger_permit <= 1'b0;
    end else if (commit & is_ctrl & wb_sel[0]) begin
      user_trigger_permit <= wb_dat_i[ipsl_pkg::CTRL_PERMIT_BIT];
    end
  end

  // Priority array, one byte lane per interrupt; low bits never stored
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < ipsl_pkg::NUM_IRQ; i++) begin
        prio[i] <= ipsl_pkg::RESET_PRIO;
      end
    end else if (commit & is_prio) begin
      for (int l = 0; l < ipsl_pkg::LANES; l++) begin
        if (wb_sel[l]) begin
          prio[prio_slot(prio_reg, l)] <=
            wb_dat_i[l*ipsl_pkg::PRIO_W +: ipsl_pkg::PRIO_W] & ipsl_pkg::PRIO_MASK;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt state

  logic [ipsl_pkg::NUM_IRQ-1:0] enter_vec;
  logic [ipsl_pkg::NUM_IRQ-1:0] ret_vec;
  logic [ipsl_pkg::NUM_IRQ-1:0] rise;
  logic [ipsl_pkg::NUM_IRQ-1:0] level_set;
  logic [ipsl_pkg::NUM_IRQ-1:0] pulse_set;
  logic [ipsl_pkg::NUM_IRQ-1:0] clr_eff;
  logic [ipsl_pkg::NUM_IRQ-1:0] next_active;
  logic [ipsl_pkg::NUM_IRQ-1:0] next_pending;

  // Handler entry and return, one bit per interrupt
  assign enter_vec = one_hot(cpu_req.enter, cpu_req.num);
  assign ret_vec = one_hot(cpu_req.ret, cpu_req.num);

  // Lines are synchronous to clk; the previous sample gives the edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_lines <= '0;
    end else begin
      prev_lines <= irq_lines;
    end
  end

  // prev_lines resets low, so a line already high at release counts as an edge
  assign rise = irq_lines & ~prev_lines;
  // Pulse lines latch on an edge, even while active
  assign pulse_set = rise & LINE_IS_PULSE;
  // Level lines set pending only when not active after this edge; at return
  // this samples the line again
  assign level_set = irq_lines & ~LINE_IS_PULSE & ~next_active;
  // A level clear with the line still high leaves the state alone
  assign clr_eff = sw_clr & ~(irq_lines & ~LINE_IS_PULSE);

  // Entry sets active, return drops it; return wins when both name the
  // same interrupt in one cycle
  always_comb begin
    next_active = active;
    next_active = next_active | enter_vec;
    next_active = next_active & ~ret_vec;
  end

  // Removals first, then every source on top, so sets win over entry and
  // clear in the same cycle; enable plays no part here
  always_comb begin
    next_pending = pending;
    next_pending = next_pending & ~enter_vec;
    next_pending = next_pending & ~clr_eff;
    next_pending = next_pending | level_set;
    next_pending = next_pending | pulse_set;
    next_pending = next_pending | sw_set;
    next_pending = next_pending | trig_vec;
  end

  // Pending bits, from every source and removal above
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pending <= '0;
    end else begin
      pending <= next_pending;
    end
  end

  // Active bits, following handler entry and return
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      active <= '0;
    end else begin
      active <= next_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Selection

  ipsl_pkg::ipsl_take_t best;
  logic [ipsl_pkg::NUM_IRQ-1:0] eligible;

  // Only enabled, pending and not active interrupts may be offered
  assign eligible = pending & enabled & ~active;

  // Ascending scan with strict compare keeps the lowest number on ties.
  // One cycle of latency in exchange for a short path into the core.
  // Limitation: the scan is a deep compare chain; more lines need a tree.
  always_comb begin
    best = '0;
    for (int i = 0; i < ipsl_pkg::NUM_IRQ; i++) begin
      if (eligible[i]) begin
        if (~best.valid | (prio[i] < best.prio)) begin
          best.valid = 1'b1;
          best.num = ipsl_pkg::IRQ_W'(i);
          best.prio = prio[i];
        end
      end
    end
  end

  // Offer registered, recomputed every cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      take <= '0;
    end else begin
      take <= best;
    end
  end

endmodule

`default_nettype wire

// ==== verification/ipsl_core_props.sv ====
// Checker of the bus answers and handler entry of the priority and state block
`timescale 1ns/1ps
`default_nettype none
module ipsl_core_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [ipsl_pkg::ADDR_W-1:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [ipsl_pkg::DATA_W-1:0] wb_dat_o,
  input wire logic wb_ack,
  input wire logic wb_err,
  input wire logic bus_priv,
  input wire ipsl_pkg::ipsl_cpu_req_t cpu_req,
  input wire ipsl_pkg::ipsl_take_t take
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic req;
  logic rd;
  // A request not yet answered, and a read being answered
  assign req = wb_cyc && wb_stb && !wb_ack && !wb_err;
  assign rd = wb_ack && !wb_we;
  ////////////////////////////////////////
  AST_ONE_ANSWER: assert property (req |=> wb_ack ^ wb_err)
    else $error("request not answered one cycle later");
  AST_ANSWER_PULSE: assert property ((wb_ack || wb_err) |=> !(wb_ack || wb_err))
    else $error("answer held longer than one cycle");
  AST_USER_REFUSED: assert property (req && !bus_priv && wb_adr != ipsl_pkg::OFS_TRIGGER |=> wb_err)
    else $error("unprivileged access not refused");
  AST_MISALIGNED: assert property (req && wb_adr[1:0] != 2'b00 |=> $rose(wb_err))
    else $error("misaligned access not refused");
  AST_PRIO_LOW_ZERO: assert property (rd && wb_adr >= ipsl_pkg::OFS_PRIO_BASE
    && wb_adr <= ipsl_pkg::OFS_PRIO_LAST |-> (wb_dat_o & 32'h0F0F_0F0F) == '0)
    else $error("unimplemented priority bits read nonzero");
  AST_LANE_ONLY: assert property (rd && wb_sel == 4'b0001 |-> wb_dat_o[31:8] == '0)
    else $error("unselected lanes read nonzero");
  AST_TRIG_READ: assert property (rd && wb_adr == ipsl_pkg::OFS_TRIGGER |-> wb_dat_o == '0)
    else $error("trigger register read nonzero");
  AST_ENTERED_GONE: assert property (cpu_req.enter && !cpu_req.ret
    ##1 !cpu_req.ret |=> !(take.valid && take.num == $past(cpu_req.num, 2)))
    else $error("active interrupt still offered");
  cover property (wb_err);
  cover property (cpu_req.enter);
  cover property (wb_ack && wb_adr == ipsl_pkg::OFS_TRIGGER);
endmodule
bind ipsl_core ipsl_core_props u_props (.clk(clk), .sys_rst(sys_rst), .wb_cyc(wb_cyc),
  .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_o(wb_dat_o),
  .wb_ack(wb_ack), .wb_err(wb_err), .bus_priv(bus_priv), .cpu_req(cpu_req), .take(take));
`default_nettype wire

// ==== verification/ipsl_cpu_model.sv ====
// Processor core model that enters and leaves the handlers offered by the block
`timescale 1ns/1ps
`default_nettype none
module ipsl_cpu_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic [3:0] dwell,
  input wire ipsl_pkg::ipsl_take_t take,
  output var ipsl_pkg::ipsl_cpu_req_t cpu_req,
  output logic [7:0] n_enter,
  output logic [4:0] last_num
);
  logic busy;
  logic [3:0] cnt;
  // One handler at a time, so with dwell above zero a stale offer is never entered twice
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_req <= '0;
      busy <= 1'b0;
      cnt <= 4'h0;
      n_enter <= 8'h00;
      last_num <= 5'h00;
    end else begin
      cpu_req.enter <= 1'b0;
      cpu_req.ret <= 1'b0;
      if (!busy && run && take.valid) begin
        cpu_req.enter <= 1'b1;
        cpu_req.num <= take.num;
        busy <= 1'b1;
        cnt <= dwell;
        n_enter <= n_enter + 8'h01;
        last_num <= take.num;
      end else if (busy && cnt == 4'h0) begin
        cpu_req.ret <= 1'b1;
        busy <= 1'b0;
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/irq_priority_and_state_logic_tb.sv ====
// Self-checking bench of the priority array, trigger and interrupt states
`timescale 1ns/1ps
`default_nettype none
module irq_priority_and_state_logic_tb;
  logic clk, sys_rst, wb_cyc, wb_stb, wb_we, wb_ack, wb_err, bus_priv, run, re;
  logic [11:0] wb_adr, a;
  logic [3:0] wb_sel, sl;
  logic [31:0] wb_dat_i, wb_dat_o, irq_lines, rq, pend, ena;
  logic [31:0] pexp [8];
  logic [7:0] n_enter;
  logic [4:0] last_num;
  ipsl_pkg::ipsl_cpu_req_t cpu_req;
  ipsl_pkg::ipsl_take_t take;
  int errors = 0, n_tests = 0, cycles = 0, seed = 32'hec68_5540, w;
  ipsl_core #(.LINE_IS_PULSE(32'hFFFF_0000)) dut (.clk(clk), .sys_rst(sys_rst),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack(wb_ack), .wb_err(wb_err),
    .bus_priv(bus_priv), .irq_lines(irq_lines), .cpu_req(cpu_req), .take(take));
  ipsl_cpu_model cpu (.clk(clk), .sys_rst(sys_rst), .run(run), .dwell(4'hF), .take(take),
    .cpu_req(cpu_req), .n_enter(n_enter), .last_num(last_num));
  ////////////////////////////////////////
  // Clock at 125 MHz
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Watchdog; the whole run needs far fewer cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Classic cycle; waits for ack or err, the watchdog bounds the wait
  task automatic bus(input logic [11:0] ad, input logic we, input logic [3:0] s,
    input logic [31:0] d, input logic pv);
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_adr <= ad;
    wb_we <= we;
    wb_sel <= s;
    wb_dat_i <= d;
    bus_priv <= pv;
    do @(posedge clk); while (wb_ack !== 1'b1 && wb_err !== 1'b1);
    rq = wb_dat_o;
    re = wb_err;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  // One-cycle pulse on the request lines
  task automatic pulse(input logic [31:0] m);
    @(posedge clk);
    irq_lines <= m;
    @(posedge clk);
    irq_lines <= '0;
  endtask
  function automatic logic [7:0] pr(input int i);
    return pexp[i/4][8*(i%4)+:8];
  endfunction
  // Most urgent: smallest value, lowest number on a tie
  function automatic int best(input logic [31:0] m);
    int b;
    b = -1;
    for (int i = 0; i < 32; i++) if (m[i] && (b < 0 || pr(i) < pr(b))) b = i;
    return b;
  endfunction
  ////////////////////////////////////////
  initial begin
    {sys_rst, wb_cyc, wb_stb, wb_we, bus_priv, run} = 6'b100000;
    {wb_adr, wb_sel, wb_dat_i, irq_lines} = '0;
    foreach (pexp[i]) pexp[i] = '0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    bus(ipsl_pkg::OFS_PRIO_LAST, 1'b0, 4'hF, '0, 1'b1);
    chk(rq, '0);
    for (int k = 0; k < 24; k++) begin
      w = k % 8;
      a = ipsl_pkg::OFS_PRIO_BASE + 12'(4 * w);
      rq = $random(seed);
      sl = $random(seed);
      for (int l = 0; l < 4; l++) if (sl[l]) pexp[w][8*l+:8] = rq[8*l+:8] & ipsl_pkg::PRIO_MASK;
      bus(a, 1'b1, sl, rq, 1'b1);
      bus(a, 1'b0, 4'hF, '0, 1'b1);
      chk(rq, pexp[w]);
      bus(a, 1'b0, 4'b0001 << (k % 4), '0, 1'b1);
      chk(rq, pexp[w] & (32'hFF << (8 * (k % 4))));
    end
    $display("test priority done");
    bus(ipsl_pkg::OFS_PRIO_BASE, 1'b1, 4'hF, '1, 1'b0);
    chk({31'h0, re}, 32'h1);
    bus(12'h401, 1'b0, 4'hF, '0, 1'b1);
    chk({31'h0, re}, 32'h1);
    bus(ipsl_pkg::OFS_TRIGGER, 1'b1, 4'hF, 32'h5, 1'b0);
    chk({31'h0, re}, 32'h1);
    bus(ipsl_pkg::OFS_CTRL, 1'b1, 4'hF, 32'h1 << ipsl_pkg::CTRL_PERMIT_BIT, 1'b0);
    chk({31'h0, re}, 32'h1);
    bus(ipsl_pkg::OFS_CTRL, 1'b1, 4'hF, 32'h1 << ipsl_pkg::CTRL_PERMIT_BIT, 1'b1);
    w = $random(seed) & 31;
    bus(ipsl_pkg::OFS_TRIGGER, 1'b1, 4'hF, 32'(w), 1'b0);
    chk({31'h0, re}, 32'h0);
    bus(ipsl_pkg::OFS_TRIGGER, 1'b1, 4'hF, 32'h28, 1'b1);
    bus(ipsl_pkg::OFS_PEND_SET, 1'b0, 4'hF, '0, 1'b1);
    chk(rq, 32'h1 << w);
    bus(ipsl_pkg::OFS_TRIGGER, 1'b0, 4'hF, '0, 1'b0);
    chk(rq, '0);
    bus(ipsl_pkg::OFS_PEND_CLR, 1'b1, 4'hF, '1, 1'b1);
    $display("test trigger done");
    pend = $random(seed) | 32'h1;
    ena = $random(seed) | 32'h1;
    bus(ipsl_pkg::OFS_PEND_SET, 1'b1, 4'hF, pend, 1'b1);
    bus(ipsl_pkg::OFS_ENA_SET, 1'b1, 4'hF, ena, 1'b1);
    w = best(pend & ena);
    repeat (2) @(posedge clk);
    chk({18'h0, take}, {18'h0, 1'b1, 5'(w), pr(w)});
    run <= 1'b1;
    while (n_enter !== 8'h01) @(posedge clk);
    run <= 1'b0;
    chk({27'h0, last_num}, 32'(w));
    bus(ipsl_pkg::OFS_ACTIVE, 1'b0, 4'hF, '0, 1'b1);
    chk(rq, 32'h1 << w);
    bus(ipsl_pkg::OFS_PEND_SET, 1'b0, 4'hF, '0, 1'b1);
    chk(rq, pend & ~(32'h1 << w));
    repeat (20) @(posedge clk);
    bus(ipsl_pkg::OFS_ACTIVE, 1'b0, 4'hF, '0, 1'b1);
    chk(rq, '0);
    bus(ipsl_pkg::OFS_PEND_CLR, 1'b1, 4'hF, '1, 1'b1);
    bus(ipsl_pkg::OFS_ENA_CLR, 1'b1, 4'hF, '1, 1'b1);
    $display("test arbitration done");
    irq_lines <= 32'h8;
    bus(ipsl_pkg::OFS_PEND_CLR, 1'b1, 4'hF, 32'h8, 1'b1);
    bus(ipsl_pkg::OFS_PEND_SET, 1'b0, 4'hF, '0, 1'b1);
    chk(rq, 32'h8);
    irq_lines <= '0;
    bus(ipsl_pkg::OFS_PEND_CLR, 1'b1, 4'hF, 32'h8, 1'b1);
    pulse(32'h0010_0000);
    bus(ipsl_pkg::OFS_PEND_SET, 1'b0, 4'hF, '0, 1'b1);
    chk(rq, 32'h0010_0000);
    bus(ipsl_pkg::OFS_ENA_SET, 1'b1, 4'hF, 32'h0010_0000, 1'b1);
    run <= 1'b1;
    while (n_enter !== 8'h02) @(posedge clk);
    run <= 1'b0;
    pulse(32'h0010_0000);
    bus(ipsl_pkg::OFS_PEND_SET, 1'b0, 4'hF, '0, 1'b1);
    chk(rq, 32'h0010_0000);
    bus(ipsl_pkg::OFS_PEND_CLR, 1'b1, 4'hF, 32'h0010_0000, 1'b1);
    bus(ipsl_pkg::OFS_ACTIVE, 1'b0, 4'hF, '0, 1'b1);
    chk(rq, 32'h0010_0000);
    bus(ipsl_pkg::OFS_PEND_SET, 1'b0, 4'hF, '0, 1'b1);
    chk(rq, '0);
    pulse(32'h0010_0000);
    repeat (20) @(posedge clk);
    bus(ipsl_pkg::OFS_PEND_SET, 1'b0, 4'hF, '0, 1'b1);
    chk(rq, 32'h0010_0000);
    bus(ipsl_pkg::OFS_ACTIVE, 1'b0, 4'hF, '0, 1'b1);
    chk(rq, '0);
    $display("test lines done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
